// ===== hw/scg_clkgen3.sv
// clock generator 3 rate select, phase shift and control register file
//
// Summary of operation
// - both select bits set means video-lock mode
// - mode bit 7: 0 NTSC, 1 PAL
// - video rate equals base over divisor
// - base code table, one NTSC-only code (5)
// - divisor codes 0000-0111 give 1-8
// - mode resets 00ff, held during reset/power-down
// - reference bit clear: rate word in hertz
// - rate word resets bb80, held during reset/power-down
// - phase bit 8: advance or retard
// - phase low byte: 0.12 degree counts
// - magnitude decrements one count at 3.072 MHz
// - phase read returns count sampled at frame
// - new phase value replaces remaining count
// - write returns previous contents on the next clock
// - phase clears on reset, power-down, disable
`timescale 1ns/100ps

module scg_clkgen3
    import scg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        power_down_pin_n_i,
    input  wire logic        generator_enable_bit_i,
    input  wire logic        frame_start_i,
    input  wire scg_req_t    ctrl_req_i,
    output logic [15:0]      ret_data_o,
    output logic             conv_tick_o,
    output logic [15:0]      conv_rate_hz_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // base frequency for a video-lock selection; unlisted codes fall back to 48000
    function automatic logic [15:0] base_hz(input scg_vmode_t m);
        case (m.base)
            3'd0:    base_hz = BASE_48000;
            3'd1:    base_hz = BASE_32000;
            3'd2:    base_hz = BASE_44100;
            3'd3:    base_hz = BASE_29400;
            3'd4:    base_hz = BASE_48000;
            3'd5:    base_hz = m.std ? BASE_48000 : BASE_44056;
            default: base_hz = BASE_48000;
        endcase
    endfunction

    // divisor 1..8 from the low code; codes with bit 3 set divide by one
    function automatic logic [3:0] div_of(input logic [3:0] code);
        div_of = code[3] ? 4'd1 : {1'b0, code[2:0]} + 4'd1;
    endfunction

    logic [15:0] mode_q;
    logic [15:0] rate_q;
    logic        ph_dir_q;
    logic [7:0]  ph_mag_q;
    logic [7:0]  ph_snap_q;
    logic [6:0]  ph_cnt_q;
    logic        ph_tick;
    logic [28:0] acc_q;
    logic [28:0] acc_sum;
    logic        hold;
    logic        ph_hold;
    logic        wr_mode;
    logic        wr_rate;
    logic        wr_phase;
    logic        video;
    scg_vmode_t  vmode;
    logic [15:0] target_d;

    // register holds and write decodes
    assign hold     = rst_i | ~power_down_pin_n_i;
    assign ph_hold  = hold | ~generator_enable_bit_i;
    assign wr_mode  = ctrl_req_i.wr & (ctrl_req_i.addr == REG_MODE_IDX);
    assign wr_rate  = ctrl_req_i.wr & (ctrl_req_i.addr == REG_RATE_IDX);
    assign wr_phase = ctrl_req_i.wr & (ctrl_req_i.addr == REG_PHASE_IDX);
    assign video    = mode_q[REF_SEL_BIT] & mode_q[VID_SEL_BIT];
    assign vmode    = mode_q[7:0];

    ////////////////////////////////////////////////////////////////////////
    // control registers

    // mode select register
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            mode_q <= MODE_RST;
        end else if (wr_mode) begin
            mode_q <= ctrl_req_i.data;
        end
    end

    // rate word register
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            rate_q <= RATE_RST;
        end else if (wr_rate) begin
            rate_q <= ctrl_req_i.data;
        end
    end

    // phase register: a write replaces whatever is still pending
    always_ff @(posedge clk_sys_i) begin
        if (ph_hold) begin
            ph_dir_q <= PHASE_RST[PH_DIR_BIT];
            ph_mag_q <= PHASE_RST[7:0];
        end else if (wr_phase) begin
            ph_dir_q <= ctrl_req_i.data[PH_DIR_BIT];
            ph_mag_q <= ctrl_req_i.data[7:0];
        end else if (ph_tick && ph_mag_q != 8'h00) begin
            ph_mag_q <= ph_mag_q - 8'd1;
        end
    end

    // remaining count captured at frame start for read-back
    always_ff @(posedge clk_sys_i) begin
        if (ph_hold) begin
            ph_snap_q <= 8'h00;
        end else if (frame_start_i) begin
            ph_snap_q <= ph_mag_q;
        end
    end

    // answer word for slot 1: old contents on a write, current on a read
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ret_data_o <= 16'h0000;
        end else if (ctrl_req_i.wr || ctrl_req_i.rd) begin
            case (ctrl_req_i.addr)
                REG_MODE_IDX:  ret_data_o <= mode_q;
                REG_RATE_IDX:  ret_data_o <= rate_q;
                REG_PHASE_IDX: ret_data_o <= {7'h00, ph_dir_q, ph_snap_q};
                default:       ret_data_o <= 16'h0000; // unmapped reads as zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rate selection and sample clock

    // chosen conversion rate in hertz
    always_comb begin
        if (video) begin
            target_d = base_hz(vmode) / {12'h000, div_of(vmode.div)};
        end else begin
            target_d = rate_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            conv_rate_hz_o <= RATE_RST;
        end else begin
            conv_rate_hz_o <= target_d;
        end
    end

    // phase processing strobe at the decrement rate
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || ph_cnt_q == PH_TICK_LAST) begin
            ph_cnt_q <= 7'h00;
        end else begin
            ph_cnt_q <= ph_cnt_q + 7'd1;
        end
    end
    assign ph_tick = (ph_cnt_q == PH_TICK_LAST);

    // accumulator sum for this cycle: the rate, nudged by one phase step per processed count
    always_comb begin
        acc_sum = acc_q + {13'h0, conv_rate_hz_o};
        if (ph_tick && ph_mag_q != 8'h00) begin
            if (!ph_dir_q) begin
                acc_sum = acc_sum + PH_STEP; // advance
            end else if (acc_sum >= PH_STEP) begin
                acc_sum = acc_sum - PH_STEP; // retard
            end else begin
                acc_sum = acc_sum + NCO_MOD - PH_STEP; // retard past zero wraps back a period
            end
        end
    end

    // phase accumulator: wraps at the system clock rate, one sample tick per wrap
    always_ff @(posedge clk_sys_i) begin
        if (hold) begin
            acc_q       <= 29'h0000000;
            conv_tick_o <= 1'b0;
        end else if (acc_sum >= NCO_MOD) begin
            acc_q       <= acc_sum - NCO_MOD;
            conv_tick_o <= 1'b1;
        end else begin
            acc_q       <= acc_sum;
            conv_tick_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i); endclocking

    a_mode_held: assert property (hold |=> mode_q == MODE_RST)
        else $error("mode register not held at reset value");
    a_rate_held: assert property (hold |=> rate_q == RATE_RST)
        else $error("rate word not held at reset value");
    a_phase_cleared: assert property (!generator_enable_bit_i |=> ph_mag_q == 8'h00 && !ph_dir_q)
        else $error("phase register not cleared while disabled");
    a_phase_replace: assert property (disable iff (ph_hold) wr_phase |=> ph_mag_q == $past(ctrl_req_i.data[7:0]))
        else $error("phase write did not replace pending count");
    a_phase_decrement: assert property (disable iff (ph_hold) (ph_tick && ph_mag_q != 8'h00 && !wr_phase)
        |=> ph_mag_q == $past(ph_mag_q) - 8'd1)
        else $error("phase count did not decrement on tick");
    a_tick_spacing: assert property (disable iff (rst_i) ph_tick |=> !ph_tick [*8])
        else $error("phase ticks too close together");
    a_snap_frame: assert property (disable iff (ph_hold) frame_start_i |=> ph_snap_q == $past(ph_mag_q))
        else $error("phase snapshot not taken at frame start");
    a_old_returned: assert property (disable iff (rst_i) (wr_mode && !hold) |=> ret_data_o == $past(mode_q))
        else $error("write did not return previous contents");
    a_direct_rate: assert property (disable iff (hold) !mode_q[REF_SEL_BIT] |=> conv_rate_hz_o == $past(rate_q))
        else $error("direct rate word not applied");
    a_video_rate: assert property (disable iff (hold) (video && mode_q[7:0] == 8'h01)
        |=> conv_rate_hz_o == 16'h5dc0)
        else $error("video rate 48000 over 2 not selected");
    a_pal_fallback: assert property (disable iff (hold) (video && mode_q[7:0] == 8'hd0)
        |=> conv_rate_hz_o == BASE_48000)
        else $error("PAL code 101 did not fall back to 48000");
    a_phase_advance: assert property (disable iff (hold) (ph_tick && ph_mag_q != 8'h00 && !ph_dir_q)
        |=> acc_q == $past(acc_q) + {13'h0, $past(conv_rate_hz_o)} + PH_STEP
            || acc_q + NCO_MOD == $past(acc_q) + {13'h0, $past(conv_rate_hz_o)} + PH_STEP)
        else $error("phase advance step not applied");
    a_phase_retard: assert property (disable iff (hold) (ph_tick && ph_mag_q != 8'h00 && ph_dir_q)
        |=> acc_q + PH_STEP == $past(acc_q) + {13'h0, $past(conv_rate_hz_o)}
            || acc_q + PH_STEP + NCO_MOD == $past(acc_q) + {13'h0, $past(conv_rate_hz_o)}
            || acc_q + PH_STEP == $past(acc_q) + {13'h0, $past(conv_rate_hz_o)} + NCO_MOD)
        else $error("phase retard step not applied");

    c_video_mode: cover property (disable iff (hold) video && vmode.div == 4'h3);
    c_retard_done: cover property (disable iff (ph_hold) ph_dir_q && ph_mag_q == 8'h01 && ph_tick);
    c_overwrite: cover property (disable iff (ph_hold) wr_phase && ph_mag_q != 8'h00);
    c_conv_tick: cover property (disable iff (hold) conv_tick_o);

endmodule

// ===== hw/scg_pkg.sv
// package: register map, field layout, reset values and timing for clock generator 3
package scg_pkg;

    // register indices on the serial control frame
    localparam logic [6:0]  REG_MODE_IDX   = 7'h16;
    localparam logic [6:0]  REG_RATE_IDX   = 7'h17;
    localparam logic [6:0]  REG_PHASE_IDX  = 7'h18;

    // values after reset
    localparam logic [15:0] MODE_RST       = 16'h00ff;
    localparam logic [15:0] RATE_RST       = 16'hbb80;
    localparam logic [15:0] PHASE_RST      = 16'h0000;

    // field positions
    localparam int          REF_SEL_BIT    = 15;
    localparam int          VID_SEL_BIT    = 14;
    localparam int          VID_STD_BIT    = 7;
    localparam int          PH_DIR_BIT     = 8;

    // base conversion rates in hertz
    localparam logic [15:0] BASE_48000     = 16'hbb80;
    localparam logic [15:0] BASE_32000     = 16'h7d00;
    localparam logic [15:0] BASE_44100     = 16'hac44;
    localparam logic [15:0] BASE_29400     = 16'h72d8;
    localparam logic [15:0] BASE_44056     = 16'hac18;

    // timing: system clock, phase processing rate and phase step size
    localparam int          CLK_HZ         = 200_000_000;
    localparam int          PH_RATE_HZ     = 3_072_000;
    localparam int          PH_TICK_CYC    = CLK_HZ / PH_RATE_HZ;      // longest spacing, rounded down
    localparam int          PH_STEPS_CYCLE = 3000;                     // 0.12 degrees per count
    localparam logic [28:0] NCO_MOD        = 29'(CLK_HZ);
    localparam logic [28:0] PH_STEP        = 29'(CLK_HZ / PH_STEPS_CYCLE);
    localparam logic [6:0]  PH_TICK_LAST   = 7'(PH_TICK_CYC - 1);

    // one control access decoded from a serial frame
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] data;
    } scg_req_t;

    // video-lock fields of the mode register
    typedef struct packed {
        logic       std;
        logic [2:0] base;
        logic [3:0] div;
    } scg_vmode_t;

endpackage

// ===== dv/scg_host_model.sv
// host side model: control accesses and frame starts
`timescale 1ns/100ps
module scg_host_model
    import scg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] ret_data_i,
    output scg_req_t         req_o,
    output logic             frame_o
);
    // no sync line here: lock runs at the nominal rate
    initial begin
        req_o = '0;
        frame_o = 1'b0;
    end
    // one access; callers keep reserved bits zero and rates in range
    task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys_i) #1;
        req_o = {w, ~w, a, d};
        @(posedge clk_sys_i) #1;
        req_o = {2'b00, ~a, ~d};
        q = ret_data_i;
    endtask
    // frame start pulse samples the remaining phase count
    task automatic frame();
        @(posedge clk_sys_i) #1;
        frame_o = 1'b1;
        @(posedge clk_sys_i) #1;
        frame_o = 1'b0;
    endtask
endmodule

// ===== dv/scg_clkgen3_bench.sv
// testbench for the clock generator 3 control block
`timescale 1ns/100ps
module scg_clkgen3_bench
    import scg_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pd_n = 1'b1;
    logic        en = 1'b1;
    logic        frame;
    logic        tick;
    scg_req_t    req;
    logic [15:0] ret, rate, q, prev, e;
    int          miscompares = 0;
    int          comparisons = 0;
    int          n;
    logic [15:0] base [6] = '{BASE_48000, BASE_32000, BASE_44100, BASE_29400, BASE_48000, BASE_44056};
    logic [3:0]  dv [7] = '{4'h2, 4'h3, 4'h6, 4'h1, 4'h0, 4'h1, 4'h4};

    ////////////////////////////////////////////////////////////////
    // clock and instances
    always #2.5 clk_sys_i = ~clk_sys_i;

    scg_clkgen3 DUT (
        .clk_sys_i              (clk_sys_i),
        .rst_i                  (rst_i),
        .power_down_pin_n_i     (pd_n),
        .generator_enable_bit_i (en),
        .frame_start_i          (frame),
        .ctrl_req_i             (req),
        .ret_data_o             (ret),
        .conv_tick_o            (tick),
        .conv_rate_hz_o         (rate)
    );
    scg_host_model HOST (
        .clk_sys_i  (clk_sys_i),
        .ret_data_i (ret),
        .req_o      (req),
        .frame_o    (frame)
    );

    ////////////////////////////////////////////////////////////////
    // compare, access and closing tasks
    task automatic rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if ($isunknown(g) || g < lo || g > hi) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        rng(g, x, x);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [15:0] x);
        HOST.access(1'b1, a, d, q);
        chk(q, x);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] x);
        HOST.access(1'b0, a, 16'h0000, q);
        chk(q, x);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic summarize();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cyc(3);
        rst_i = 1'b0;
        rd(REG_MODE_IDX, MODE_RST);
        rd(REG_RATE_IDX, RATE_RST);
        rd(REG_PHASE_IDX, PHASE_RST);
        rd(7'h19, 16'h0000);
        chk(rate, RATE_RST);
        wr(REG_RATE_IDX, 16'h1f40, RATE_RST);
        wr(REG_RATE_IDX, 16'h0fa0, 16'h1f40);
        cyc(1);
        chk(rate, 16'h0fa0);
        // base codes 0 to 5, divisors that divide exactly, then one PAL lock
        prev = MODE_RST;
        for (int i = 0; i < 7; i++) begin
            e = {2'b11, 6'h00, i == 6, (i == 6) ? 3'h2 : 3'(i), dv[i]};
            wr(REG_MODE_IDX, e, prev);
            prev = e;
            cyc(1);
            chk(rate, base[(i == 6) ? 2 : i] / (dv[i] + 16'h0001));
        end
        wr(REG_MODE_IDX, 16'h40ff, prev);
        cyc(1);
        chk(rate, 16'h0fa0);
        // tick spacing at 48 kHz is about 4167 cycles
        wr(REG_RATE_IDX, RATE_RST, 16'h0fa0);
        cyc(2);
        n = 0;
        repeat (9000) begin
            @(posedge clk_sys_i) #1;
            if (tick === 1'b1) n++;
        end
        rng(16'(n), 16'h0002, 16'h0003);
        // retard by 255 counts, about ten counts drain in 650 cycles
        wr(REG_PHASE_IDX, 16'h01ff, 16'h0000);
        cyc(650);
        HOST.frame();
        HOST.access(1'b0, REG_PHASE_IDX, 16'h0000, q);
        rng(q, 16'h01f4, 16'h01f6);
        wr(REG_PHASE_IDX, 16'h0002, q);
        cyc(300);
        HOST.frame();
        rd(REG_PHASE_IDX, 16'h0000);
        // disable clears the count and refuses writes
        wr(REG_PHASE_IDX, 16'h00aa, 16'h0000);
        en = 1'b0;
        HOST.access(1'b1, REG_PHASE_IDX, 16'h0033, q);
        en = 1'b1;
        HOST.frame();
        rd(REG_PHASE_IDX, 16'h0000);
        // power-down restores defaults and refuses writes
        wr(REG_RATE_IDX, 16'h1f40, RATE_RST);
        pd_n = 1'b0;
        HOST.access(1'b1, REG_RATE_IDX, 16'h2ee0, q);
        pd_n = 1'b1;
        rd(REG_RATE_IDX, RATE_RST);
        rd(REG_MODE_IDX, MODE_RST);
        chk(rate, RATE_RST);
        summarize();
    end
endmodule
